// >>> pkg/adrg_regs.svh
// Constants of the adapter DRAM refresh and bus glue
`ifndef ADRG_REGS_SVH
`define ADRG_REGS_SVH
`define ADRG_MCLK_HZ 250000000
`define ADRG_XTAL_HZ 16000000
`define ADRG_SYS_HZ (`ADRG_XTAL_HZ / 2)
`define ADRG_SYS_DIV (`ADRG_MCLK_HZ / `ADRG_SYS_HZ)
`define ADRG_BUS_TCYC 4
`define ADRG_BUS_NS 500
`define ADRG_DMA_CYCLES 2
`define ADRG_IO_ATTN_ADDR 16'h0000
`define ADRG_IO_REFRESH_ADDR 16'h0080
`define ADRG_SEL1_MASK 16'hFF80
`define ADRG_BANK_SHIFT 17
`define ADRG_RAM_TOP_BIT 19
`define ADRG_ROM_SMALL_TAG 6'h3F
`define ADRG_ROM_LARGE_TAG 3'h7
`define ADRG_ROWS 256
`define ADRG_RETENTION_MS 4
`define ADRG_REFRESH_US 30
`define ADRG_INIT_WAIT_US 200
`define ADRG_INIT_CYCLES 8
`define ADRG_MCLK_PER_US (`ADRG_MCLK_HZ / 1000000)
`define ADRG_REFRESH_CYC (`ADRG_REFRESH_US * `ADRG_MCLK_PER_US)
`define ADRG_INIT_WAIT_CYC (`ADRG_INIT_WAIT_US * `ADRG_MCLK_PER_US)
`endif

// >>> pkg/adrg_pkg.sv
// Types of the adapter DRAM refresh and bus glue
package adrg_pkg;
  typedef enum logic [4:0] {
    ADRG_ST_IDLE = 5'b0_0001,
    ADRG_ST_T1 = 5'b0_0010,
    ADRG_ST_T2 = 5'b0_0100,
    ADRG_ST_T3 = 5'b0_1000,
    ADRG_ST_T4 = 5'b1_0000
  } adrg_bus_e;
  typedef enum logic [3:0] {
    ADRG_K_MEM = 4'b0001,
    ADRG_K_REF = 4'b0010,
    ADRG_K_ATTN = 4'b0100,
    ADRG_K_IO = 4'b1000
  } adrg_kind_e;
  typedef enum logic [2:0] {
    ADRG_H_PWR = 3'b001,
    ADRG_H_INIT = 3'b010,
    ADRG_H_RUN = 3'b100
  } adrg_host_e;
  typedef logic [23:0] adrg_addr_t;
endpackage : adrg_pkg

// >>> pkg/adrg_if.sv
// Shared bus between the processor side and the glue logic
`timescale 1ns/1ps
interface adrg_if;
  logic cyc_start;
  adrg_pkg::adrg_addr_t cyc_addr;
  logic cyc_io;
  logic cyc_wr;
  logic cyc_coproc;
  logic cyc_dma;
  logic periph_sel1;
  logic hold_grant;
  logic coproc_irq_req;
  logic coproc_reset_bit;
  logic loopback_n;
  logic sys_en;
  logic cyc_busy;
  logic cyc_done;
  logic cyc_refused;
  logic [3:0] ras_n;
  logic cas_n;
  logic we_n;
  logic rom_sel_n;
  logic channel_attention;
  logic coproc_irq_input;
  logic coproc_reset_out;
  logic loop_route;
  logic dma_pair_done;
  modport dev (
    input cyc_start, cyc_addr, cyc_io, cyc_wr, cyc_coproc, cyc_dma, periph_sel1,
    input hold_grant, coproc_irq_req, coproc_reset_bit, loopback_n,
    output sys_en, cyc_busy, cyc_done, cyc_refused, ras_n, cas_n, we_n, rom_sel_n,
    output channel_attention, coproc_irq_input, coproc_reset_out, loop_route,
    output dma_pair_done
  );
  modport host (
    output cyc_start, cyc_addr, cyc_io, cyc_wr, cyc_coproc, cyc_dma, periph_sel1,
    output hold_grant, coproc_irq_req, coproc_reset_bit, loopback_n,
    input sys_en, cyc_busy, cyc_done, cyc_refused, ras_n, cas_n, we_n, rom_sel_n,
    input channel_attention, coproc_irq_input, coproc_reset_out, loop_route,
    input dma_pair_done
  );
endinterface : adrg_if

// >>> rtl/adrg_clk_div.sv
// Divider giving a one-cycle enable at the system clock rate
`timescale 1ns/1ps
module adrg_clk_div #(
  parameter int DIV = 31
) (
  input wire logic mclk,
  input wire logic rst,
  output logic tick
);
  logic [7:0] cnt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_q == 8'(DIV - 1)) begin
      cnt_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : adrg_clk_div

// >>> rtl/adrg_glue.sv
// Memory decode, refresh and coprocessor glue of the adapter
`timescale 1ns/1ps
`include "adrg_regs.svh"
// Behaviour
// [R01] System clock is crystal divided by two
// [R02] Bus cycle is four system clocks
// [R03] DMA transfer is fetch then deposit
// [R04] Only bus owner may run cycles
// [R05] I/O location zero strobes channel attention
// [R06] Coprocessor request drives interrupt input one
// [R07] Reset bit holds coprocessor in reset
// [R08] Loopback active while control bit clear
// [R09] Four RAM banks of 128K decoded
// [R10] ROM at top, larger when big ROM
// [R11] Coprocessor reaches ROM only after reset
// [R12] 256 rows refreshed every 4 ms
// [R13] Refresh location runs CAS-before-RAS all banks
// [R14] Refresh cycle never alters RAM contents
// [R15] Peripheral select one marks refresh range
// [R16] Timer triggers refresh DMA every 30 us
// [R17] Each DMA cycle refreshes two rows
// [R18] Refresh DMA never stops at terminal count
// [R19] One DMA cycle per timer trigger
// [R20] Power-up wait then eight init refreshes
// [R21] Without CBR, eight accesses per bank
// [R22] Coprocessor address lines 20-23 ignored
// [R23] Refresh during coprocessor hold waits for release
module adrg_glue #(
  parameter int DIV = `ADRG_SYS_DIV
) (
  input wire logic mclk,
  input wire logic rst,
  adrg_if.dev bus,
  input wire logic rom_large,
  output logic [15:0] rows_refreshed,
  output logic coproc_init
);
  import adrg_pkg::*;

  // ----------------------------------------
  // System clock enable
  // ----------------------------------------
  logic sys_en;
  // [R01] Crystal halved
  adrg_clk_div #(.DIV(DIV)) u_div (
    .mclk(mclk),
    .rst(rst),
    .tick(sys_en)
  );
  assign bus.sys_en = sys_en;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Returns {rom, bank one-hot}; zero means nothing selected
  function automatic logic [4:0] decode(input adrg_addr_t a, input logic cop,
                                        input logic init, input logic big);
    logic [19:0] p;
    logic rom;
    p = a[19:0];
    rom = big ? (p[19:17] == `ADRG_ROM_LARGE_TAG) : (p[19:14] == `ADRG_ROM_SMALL_TAG);
    if (cop && !init) begin
      rom = 1'b0;
    end
    if (rom) begin
      decode = 5'b1_0000;
    end else if (!p[`ADRG_RAM_TOP_BIT] || (cop && !init)) begin
      decode = {1'b0, 4'b0001 << p[18:`ADRG_BANK_SHIFT]};
    end else begin
      decode = 5'b0_0000;
    end
  endfunction : decode

  adrg_bus_e state_q;
  adrg_kind_e kind_q;
  logic [4:0] sel_q;
  logic wr_q;
  logic dma_q;
  logic cop_q;
  logic pend_q;
  logic dma_phase_q;
  logic rst_bit_q;
  logic owner_ok;
  logic is_ref;
  logic is_attn;
  logic go_new;
  logic go_pend;

  // [R04] Owner check
  assign owner_ok = (bus.cyc_coproc == bus.hold_grant);
  // [R15] Refresh range select
  assign is_ref = bus.cyc_io && bus.periph_sel1;
  assign is_attn = bus.cyc_io && (bus.cyc_addr[15:0] == `ADRG_IO_ATTN_ADDR);
  // [R23] Refresh held off
  assign go_new = bus.cyc_start && (state_q == ADRG_ST_IDLE) && !pend_q && owner_ok &&
                  !(is_ref && bus.hold_grant);
  assign go_pend = pend_q && !bus.hold_grant && (state_q == ADRG_ST_IDLE);

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  // [R02] Four system clocks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ADRG_ST_IDLE;
    end else if (go_new || go_pend) begin
      state_q <= ADRG_ST_T1;
    end else if (sys_en) begin
      unique case (state_q)
        ADRG_ST_IDLE: state_q <= ADRG_ST_IDLE;
        ADRG_ST_T1: state_q <= ADRG_ST_T2;
        ADRG_ST_T2: state_q <= ADRG_ST_T3;
        ADRG_ST_T3: state_q <= ADRG_ST_T4;
        ADRG_ST_T4: state_q <= ADRG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      kind_q <= ADRG_K_IO;
      sel_q <= 5'b0_0000;
      wr_q <= 1'b0;
      dma_q <= 1'b0;
      cop_q <= 1'b0;
    end else if (go_pend) begin
      kind_q <= ADRG_K_REF;
      sel_q <= 5'b0_0000;
    end else if (go_new) begin
      wr_q <= bus.cyc_wr;
      dma_q <= bus.cyc_dma;
      cop_q <= bus.cyc_coproc;
      // [R22] Upper lines dropped
      sel_q <= bus.cyc_io ? 5'b0_0000 :
               decode(bus.cyc_addr, bus.cyc_coproc, coproc_init, rom_large);
      // [R13] Refresh kind
      kind_q <= is_ref ? ADRG_K_REF : is_attn ? ADRG_K_ATTN :
                bus.cyc_io ? ADRG_K_IO : ADRG_K_MEM;
    end
  end

  // Hardware set wins over the release by the hold handshake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (bus.cyc_start && is_ref && bus.hold_grant && !bus.cyc_coproc) begin
      pend_q <= 1'b1;
    end else if (go_pend) begin
      pend_q <= 1'b0;
    end
  end

  logic end_cyc;
  assign end_cyc = sys_en && (state_q == ADRG_ST_T4);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.cyc_done <= 1'b0;
      bus.cyc_refused <= 1'b0;
    end else begin
      bus.cyc_done <= end_cyc;
      bus.cyc_refused <= bus.cyc_start && !owner_ok;
    end
  end
  assign bus.cyc_busy = (state_q != ADRG_ST_IDLE) || pend_q;

  // ----------------------------------------
  // DRAM, ROM and attention strobes
  // ----------------------------------------
  logic [3:0] ras_d;
  logic cas_d;
  logic we_d;
  logic rom_d;
  logic attn_d;
  logic mem_c;
  logic ref_c;

  always_comb begin
    mem_c = (kind_q == ADRG_K_MEM);
    ref_c = (kind_q == ADRG_K_REF);
    ras_d = 4'hF;
    cas_d = 1'b1;
    we_d = 1'b1;
    rom_d = 1'b1;
    attn_d = 1'b0;
    unique case (state_q)
      ADRG_ST_IDLE: begin
        ras_d = 4'hF;
      end
      ADRG_ST_T1: begin
        // [R09] Bank row strobe
        ras_d = mem_c ? ~sel_q[3:0] : 4'hF;
        // [R10] ROM select
        rom_d = !(mem_c && sel_q[4]);
      end
      ADRG_ST_T2, ADRG_ST_T3: begin
        ras_d = mem_c ? ~sel_q[3:0] : 4'hF;
        rom_d = !(mem_c && sel_q[4]);
        cas_d = !((mem_c && (sel_q[3:0] != 4'h0)) || ref_c);
        we_d = !(mem_c && wr_q && (sel_q[3:0] != 4'h0));
        // [R13] CAS first, then RAS in every bank
        if (ref_c && state_q == ADRG_ST_T3) begin
          ras_d = 4'h0;
        end
        // [R05] Attention pulse
        attn_d = (kind_q == ADRG_K_ATTN);
      end
      ADRG_ST_T4: begin
        // Precharge in T4, except on refresh where RAS stays low, keeps the next cycle free of wait states
        ras_d = ref_c ? 4'h0 : 4'hF;
        rom_d = !(mem_c && sel_q[4]);
      end
    endcase
    // [R14] Write strobe masked on refresh
    if (ref_c) begin
      we_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.ras_n <= 4'hF;
      bus.cas_n <= 1'b1;
      bus.we_n <= 1'b1;
      bus.rom_sel_n <= 1'b1;
      bus.channel_attention <= 1'b0;
    end else begin
      bus.ras_n <= ras_d;
      bus.cas_n <= cas_d;
      bus.we_n <= we_d;
      bus.rom_sel_n <= rom_d;
      bus.channel_attention <= attn_d;
    end
  end

  // ----------------------------------------
  // DMA pairing and refresh count
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dma_phase_q <= 1'b0;
      bus.dma_pair_done <= 1'b0;
    end else begin
      bus.dma_pair_done <= 1'b0;
      // [R03] Fetch then deposit
      if (end_cyc && dma_q) begin
        dma_phase_q <= !dma_phase_q;
        bus.dma_pair_done <= dma_phase_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rows_refreshed <= 16'h0000;
    end else if (end_cyc && kind_q == ADRG_K_REF) begin
      // [R17] Row per refresh access
      rows_refreshed <= rows_refreshed + 16'h0001;
    end
  end

  // ----------------------------------------
  // Coprocessor control
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_bit_q <= 1'b1;
      bus.coproc_reset_out <= 1'b1;
      bus.coproc_irq_input <= 1'b0;
      bus.loop_route <= 1'b0;
    end else begin
      rst_bit_q <= bus.coproc_reset_bit;
      // [R07] Reset follows bit
      bus.coproc_reset_out <= bus.coproc_reset_bit;
      // [R06] Interrupt input one
      bus.coproc_irq_input <= bus.coproc_irq_req;
      // [R08] Active low loopback
      bus.loop_route <= !bus.loopback_n;
    end
  end

  // Root fetch window opens on reset release, closes on first coprocessor RAM access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coproc_init <= 1'b0;
    end else if (rst_bit_q && !bus.coproc_reset_bit) begin
      // [R11] ROM window
      coproc_init <= 1'b1;
    end else if (end_cyc && cop_q && (sel_q[3:0] != 4'h0)) begin
      coproc_init <= 1'b0;
    end
  end
endmodule : adrg_glue

// >>> rtl/adrg_host.sv
// Processor-side bus master: refresh timer, init and arbitration
`timescale 1ns/1ps
`include "adrg_regs.svh"
module adrg_host #(
  parameter int WAIT_CYC = `ADRG_INIT_WAIT_CYC,
  parameter int TMR_CYC = `ADRG_REFRESH_CYC,
  parameter int NBANKS = 4,
  parameter bit USE_CBR = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  adrg_if.host bus,
  input wire logic usr_req,
  input wire adrg_pkg::adrg_addr_t usr_addr,
  input wire logic usr_io,
  input wire logic usr_wr,
  output logic usr_ack,
  input wire logic cop_hold_req,
  input wire logic cop_req,
  input wire adrg_pkg::adrg_addr_t cop_addr,
  input wire logic cop_wr,
  output logic cop_ack,
  input wire logic cop_irq,
  input wire logic reset_bit,
  input wire logic loopback_n,
  output logic init_done
);
  import adrg_pkg::*;

  // ----------------------------------------
  // Refresh engine
  // ----------------------------------------
  adrg_host_e st_q;
  logic [16:0] cnt_q;
  logic [5:0] init_left_q;
  logic [1:0] dma_pend_q;
  logic out_q;
  logic go;
  logic pick_cop;
  logic pick_ref;
  logic pick_usr;
  logic ref_need;
  logic [5:0] init_total;
  logic [5:0] init_idx;

  assign init_total = USE_CBR ? 6'(`ADRG_INIT_CYCLES) : 6'(`ADRG_INIT_CYCLES * NBANKS);
  assign init_idx = init_total - init_left_q;
  assign ref_need = (st_q == ADRG_H_INIT && init_left_q != 6'h00) || (dma_pend_q != 2'b00);
  assign init_done = (st_q == ADRG_H_RUN);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ADRG_H_PWR;
      cnt_q <= 17'h0_0000;
      init_left_q <= 6'h00;
      dma_pend_q <= 2'b00;
    end else begin
      unique case (st_q)
        // [R20] Power-up wait
        ADRG_H_PWR: begin
          if (cnt_q == 17'(WAIT_CYC - 1)) begin
            st_q <= ADRG_H_INIT;
            cnt_q <= 17'h0_0000;
            init_left_q <= init_total;
          end else begin
            cnt_q <= cnt_q + 17'h0_0001;
          end
        end
        ADRG_H_INIT: begin
          if (go && pick_ref) begin
            init_left_q <= init_left_q - 6'h01;
          end
          if (init_left_q == 6'h00 && !out_q) begin
            st_q <= ADRG_H_RUN;
          end
        end
        // [R18] Timer never stops
        ADRG_H_RUN: begin
          // [R12] Rows within retention
          // [R16] Periodic trigger
          if (cnt_q == 17'(TMR_CYC - 1)) begin
            cnt_q <= 17'h0_0000;
          end else begin
            cnt_q <= cnt_q + 17'h0_0001;
          end
          if (go && pick_ref) begin
            dma_pend_q <= {dma_pend_q[0], 1'b0};
          end else if (cnt_q == 17'(TMR_CYC - 1) && dma_pend_q == 2'b00) begin
            // [R19] Single DMA per trigger
            dma_pend_q <= 2'b01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Arbitration and cycle issue
  // ----------------------------------------
  // [R04] Grant changes only between cycles
  assign pick_cop = bus.hold_grant && cop_req;
  // [R23] No refresh under hold
  assign pick_ref = !bus.hold_grant && ref_need;
  assign pick_usr = !bus.hold_grant && !ref_need && usr_req;
  assign go = !out_q && !bus.cyc_start && (pick_cop || pick_ref || pick_usr);
  assign usr_ack = go && pick_usr;
  assign cop_ack = go && pick_cop;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.hold_grant <= 1'b0;
      out_q <= 1'b0;
    end else begin
      if (!out_q && !bus.cyc_start && !go) begin
        bus.hold_grant <= cop_hold_req;
      end
      if (go) begin
        out_q <= 1'b1;
      end else if (bus.cyc_done || bus.cyc_refused) begin
        out_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.cyc_start <= 1'b0;
      bus.cyc_addr <= 24'h00_0000;
      bus.cyc_io <= 1'b0;
      bus.cyc_wr <= 1'b0;
      bus.cyc_coproc <= 1'b0;
      bus.cyc_dma <= 1'b0;
      bus.periph_sel1 <= 1'b0;
    end else begin
      bus.cyc_start <= go;
      if (go) begin
        bus.cyc_coproc <= pick_cop;
        bus.cyc_dma <= pick_ref && (st_q == ADRG_H_RUN);
        if (pick_cop) begin
          bus.cyc_addr <= cop_addr;
          bus.cyc_io <= 1'b0;
          bus.cyc_wr <= cop_wr;
        end else if (pick_ref && (USE_CBR || st_q == ADRG_H_RUN)) begin
          // [R17] Read then write of refresh location
          bus.cyc_addr <= {8'h00, `ADRG_IO_REFRESH_ADDR};
          bus.cyc_io <= 1'b1;
          bus.cyc_wr <= dma_pend_q[1];
        end else if (pick_ref) begin
          // [R21] Reads spread over every bank
          bus.cyc_addr <= 24'({init_idx[4:3], 17'h0_0000});
          bus.cyc_io <= 1'b0;
          bus.cyc_wr <= 1'b0;
        end else begin
          bus.cyc_addr <= usr_addr;
          bus.cyc_io <= usr_io;
          bus.cyc_wr <= usr_wr;
        end
        bus.periph_sel1 <= (pick_ref && (USE_CBR || st_q == ADRG_H_RUN)) ||
                           (pick_usr && usr_io &&
                            ((usr_addr[15:0] & `ADRG_SEL1_MASK) == `ADRG_IO_REFRESH_ADDR));
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.coproc_irq_req <= 1'b0;
      bus.coproc_reset_bit <= 1'b1;
      bus.loopback_n <= 1'b1;
    end else begin
      bus.coproc_irq_req <= cop_irq;
      bus.coproc_reset_bit <= reset_bit;
      bus.loopback_n <= loopback_n;
    end
  end
endmodule : adrg_host

// >>> bench/adrg_props.sv
// Checker for the bus between processor side and glue logic
`timescale 1ns/1ps
module adrg_props #(
  parameter int DIV = 31
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_start,
  input wire adrg_pkg::adrg_addr_t cyc_addr,
  input wire logic cyc_io,
  input wire logic cyc_wr,
  input wire logic cyc_coproc,
  input wire logic cyc_dma,
  input wire logic periph_sel1,
  input wire logic hold_grant,
  input wire logic coproc_irq_req,
  input wire logic coproc_reset_bit,
  input wire logic loopback_n,
  input wire logic cyc_busy,
  input wire logic cyc_done,
  input wire logic [3:0] ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic rom_sel_n,
  input wire logic channel_attention,
  input wire logic coproc_irq_input,
  input wire logic coproc_reset_out,
  input wire logic loop_route,
  input wire logic dma_pair_done
);
  import adrg_pkg::*;
  // Slack of two mclk each side for the sys_en phase
  localparam int DONE_LO = 3 * DIV;
  localparam int DONE_HI = 4 * DIV + 3;
  localparam int PEND_HI = 4 * DIV + 6;
  logic take;
  assign take = cyc_start && !cyc_busy && (cyc_coproc == hold_grant);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_attn_io_zero: assert property (
    take && cyc_io && (cyc_addr[15:0] == 16'h0000) |-> ##[1:DONE_HI] channel_attention)
    else $error("channel attention missing");
  chk_attn_in_io: assert property (channel_attention |-> cyc_io && cyc_busy)
    else $error("channel attention outside io cycle");
  chk_cycle_len: assert property (
    take && !(cyc_io && periph_sel1 && hold_grant) |-> ##[DONE_LO:DONE_HI] cyc_done)
    else $error("bus cycle length wrong");
  chk_cbr_order: assert property ($fell(ras_n[0]) && (ras_n == 4'h0) |-> !cas_n)
    else $error("cas not ahead of ras");
  chk_refresh_nowr: assert property (
    (ras_n == 4'h0) |-> we_n && cyc_io && periph_sel1)
    else $error("refresh strobes wrong");
  chk_bank_decode: assert property (
    (ras_n != 4'hF) && (ras_n != 4'h0) |-> $onehot(~ras_n) && !ras_n[cyc_addr[18:17]] && !cyc_io)
    else $error("bank decode wrong");
  chk_rom_decode: assert property (
    !rom_sel_n |-> (ras_n == 4'hF) && (cyc_addr[19:17] == 3'h7) && !cyc_io)
    else $error("rom select wrong");
  chk_irq_route: assert property ($rose(coproc_irq_req) |-> ##1 coproc_irq_input)
    else $error("irq not routed");
  chk_reset_follow: assert property (
    $changed(coproc_reset_bit) |=> (coproc_reset_out == $past(coproc_reset_bit)))
    else $error("coprocessor reset wrong");
  chk_loop_pol: assert property (
    $changed(loopback_n) |=> (loop_route == !$past(loopback_n)))
    else $error("loopback polarity wrong");
  chk_dma_pair: assert property (
    dma_pair_done |-> cyc_done && cyc_dma && cyc_wr)
    else $error("dma pair order wrong");
  chk_grant_owner: assert property (cyc_start && cyc_coproc |-> hold_grant)
    else $error("coprocessor cycle without grant");
  chk_pend_refresh: assert property (
    $fell(hold_grant) && cyc_busy |-> ##[1:PEND_HI] cyc_done)
    else $error("pending refresh lost");
  cov_attn: cover property (channel_attention);
  cov_pair: cover property (dma_pair_done);
  cov_cbr: cover property (ras_n == 4'h0);
  cov_cop_rom: cover property (!rom_sel_n && cyc_coproc);
endmodule : adrg_props

// >>> bench/tb_top.sv
// Bench joining processor side and glue logic
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import adrg_pkg::*;
  localparam int DIV = 4;
  localparam int TMR = 200;
  logic mclk, rst, usr_req, usr_io, usr_wr, usr_ack, cop_hold_req, cop_req, cop_wr, cop_ack;
  logic cop_irq, reset_bit, loopback_n, init_done, rom_large, coproc_init;
  adrg_addr_t usr_addr, cop_addr;
  logic [15:0] rows_refreshed, ref_cnt;
  logic [3:0] seen_ras;
  logic seen_rom, seen_attn, seen_we, seen_cbr, got_done, dma_last_wr;
  adrg_addr_t want;
  int bad_count, num_checks, pair_cnt, dma_err, cycles;
  adrg_if bus_if();
  adrg_glue #(.DIV(DIV)) u_adrg_glue (.mclk(mclk), .rst(rst), .bus(bus_if),
    .rom_large(rom_large), .rows_refreshed(rows_refreshed), .coproc_init(coproc_init));
  adrg_host #(.WAIT_CYC(20), .TMR_CYC(TMR), .NBANKS(4), .USE_CBR(1'b1)) u_adrg_host (
    .mclk(mclk), .rst(rst), .bus(bus_if), .usr_req(usr_req), .usr_addr(usr_addr),
    .usr_io(usr_io), .usr_wr(usr_wr), .usr_ack(usr_ack), .cop_hold_req(cop_hold_req),
    .cop_req(cop_req), .cop_addr(cop_addr), .cop_wr(cop_wr), .cop_ack(cop_ack),
    .cop_irq(cop_irq), .reset_bit(reset_bit), .loopback_n(loopback_n), .init_done(init_done));
  adrg_props #(.DIV(DIV)) u_adrg_props (.mclk(mclk), .rst(rst), .cyc_start(bus_if.cyc_start),
    .cyc_addr(bus_if.cyc_addr), .cyc_io(bus_if.cyc_io), .cyc_wr(bus_if.cyc_wr),
    .cyc_coproc(bus_if.cyc_coproc), .cyc_dma(bus_if.cyc_dma),
    .periph_sel1(bus_if.periph_sel1), .hold_grant(bus_if.hold_grant),
    .coproc_irq_req(bus_if.coproc_irq_req), .coproc_reset_bit(bus_if.coproc_reset_bit),
    .loopback_n(bus_if.loopback_n), .cyc_busy(bus_if.cyc_busy), .cyc_done(bus_if.cyc_done),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
    .rom_sel_n(bus_if.rom_sel_n), .channel_attention(bus_if.channel_attention),
    .coproc_irq_input(bus_if.coproc_irq_input), .coproc_reset_out(bus_if.coproc_reset_out),
    .loop_route(bus_if.loop_route), .dma_pair_done(bus_if.dma_pair_done));
  // ----------------------------------------
  // Clock and monitor
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Sampled at negedge so flop updates have landed
  always @(negedge mclk) begin
    cycles++;
    if (bus_if.ras_n != 4'hF && bus_if.ras_n != 4'h0) seen_ras |= ~bus_if.ras_n;
    if (!bus_if.rom_sel_n) seen_rom = 1'b1;
    if (bus_if.channel_attention) seen_attn = 1'b1;
    if (!bus_if.we_n) seen_we = 1'b1;
    // Timer refresh may land inside any scenario
    if (bus_if.ras_n == 4'h0 && !bus_if.cas_n && !bus_if.cyc_dma) seen_cbr = 1'b1;
    if (bus_if.cyc_done && bus_if.cyc_addr === want && !bus_if.cyc_dma) got_done = 1'b1;
    if (bus_if.cyc_done && bus_if.cyc_io && bus_if.periph_sel1) ref_cnt++;
    if (bus_if.dma_pair_done) pair_cnt++;
    if (bus_if.cyc_done && bus_if.cyc_dma) begin
      if (bus_if.cyc_wr === dma_last_wr) dma_err++;
      dma_last_wr = bus_if.cyc_wr;
    end
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // One bus cycle from processor or coprocessor, waits for its own completion
  task automatic cyc(input bit cop, input adrg_addr_t a, input bit io, input bit wr);
    int n;
    n = 0;
    seen_ras = 4'h0; seen_rom = 0; seen_attn = 0; seen_we = 0; seen_cbr = 0; got_done = 0;
    want = a;
    if (cop) begin cop_req = 1'b1; cop_addr = a; cop_wr = wr; end
    else begin usr_req = 1'b1; usr_addr = a; usr_io = io; usr_wr = wr; end
    // Ack is combinational; read it mid-cycle once settled
    while ((cop ? cop_ack : usr_ack) !== 1'b1 && n < 400) begin
      @(negedge mclk); n++;
    end
    @(posedge mclk); #1;
    usr_req = 1'b0;
    cop_req = 1'b0;
    n = 0;
    while (!got_done && n < 400) begin @(posedge mclk); #1; n++; end
    `CHK(got_done, 1'b1)
  endtask : cyc
  task automatic t_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin @(posedge mclk); #1; n++; end
    repeat (2) @(posedge mclk);
    #1;
    `CHK(rows_refreshed, 16'h0008)
    $display("test init done");
  endtask : t_init
  task automatic t_mem();
    adrg_addr_t a[4] = '{24'h00_0100, 24'hF2_0000, 24'h05_FFFE, 24'h07_8000};
    for (int i = 0; i < 4; i++) begin
      cyc(0, a[i], 0, i[0]);
      `CHK(seen_ras, 4'h1 << i)
      `CHK(seen_we, i[0])
    end
    cyc(0, 24'h0F_FFF6, 0, 0);
    `CHK({seen_rom, seen_ras}, 5'h10)
    cyc(0, 24'h0E_0000, 0, 0);
    `CHK({seen_rom, seen_ras}, 5'h00)
    rom_large = 1'b1;
    cyc(0, 24'h0E_0000, 0, 0);
    `CHK({seen_rom, seen_ras}, 5'h10)
    rom_large = 1'b0;
    $display("test mem done");
  endtask : t_mem
  task automatic t_io();
    for (int i = 0; i < 2; i++) begin
      cyc(0, 24'h00_0000, 1, i[0]);
      `CHK({seen_attn, seen_cbr}, 2'b10)
      cyc(0, 24'h00_0080, 1, i[0]);
      `CHK({seen_attn, seen_cbr, seen_we, seen_ras}, 7'h20)
    end
    cyc(0, 24'h00_00FF, 1, 1);
    `CHK(seen_cbr, 1'b1)
    cyc(0, 24'h00_0100, 1, 1);
    `CHK({seen_attn, seen_cbr}, 2'b00)
    $display("test io done");
  endtask : t_io
  task automatic t_dma();
    pair_cnt = 0;
    // Negedge end keeps the monitor counts level with the design
    repeat (5 * TMR) @(negedge mclk);
    #1;
    `CHK(pair_cnt, 5)
    `CHK(dma_err, 0)
    `CHK(rows_refreshed, ref_cnt)
    $display("test dma done");
  endtask : t_dma
  task automatic t_side();
    cop_irq = 1'b1;
    loopback_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK({bus_if.coproc_irq_input, bus_if.loop_route, bus_if.coproc_reset_out}, 3'b111)
    cop_irq = 1'b0;
    loopback_n = 1'b1;
    reset_bit = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK({bus_if.coproc_irq_input, bus_if.loop_route, bus_if.coproc_reset_out}, 3'b000)
    $display("test side done");
  endtask : t_side
  task automatic t_cop();
    int n;
    n = 0;
    cop_hold_req = 1'b1;
    while (bus_if.hold_grant !== 1'b1 && n < 400) begin @(posedge mclk); #1; n++; end
    `CHK(coproc_init, 1'b1)
    cyc(1, 24'hFF_FFF6, 0, 0);
    `CHK({seen_rom, seen_ras}, 5'h10)
    cyc(1, 24'h00_1000, 0, 1);
    `CHK(seen_ras, 4'h1)
    cyc(1, 24'hFF_FFF6, 0, 0);
    `CHK({seen_rom, seen_ras}, 5'h08)
    cop_hold_req = 1'b0;
    repeat (2 * TMR) @(negedge mclk);
    #1;
    `CHK(rows_refreshed, ref_cnt)
    $display("test cop done");
  endtask : t_cop
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; usr_req = 0; usr_io = 0; usr_wr = 0; usr_addr = '0; cop_hold_req = 0;
    cop_req = 0; cop_addr = '0; cop_wr = 0; cop_irq = 0; reset_bit = 1; loopback_n = 1;
    rom_large = 0; ref_cnt = '0; want = '1; dma_last_wr = 1'b1;
    bad_count = 0; num_checks = 0; pair_cnt = 0; dma_err = 0; cycles = 0;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_init();
    t_mem();
    t_io();
    t_dma();
    t_side();
    t_cop();
    finish_test();
  end
endmodule : tb_top
